// ### shared/pwn_pkg.sv
// Constants for the notification packet generator
// Summary of operation
// - Generation active after reset; a port with notifyDisable set starts no new notification, but a port already in service keeps retrying.
// - Enabled capable events cause a notification to the programmed target destination.
// - Events whose interrupt enable is clear never produce a notification.
// - Each qualifying event requests a notification, regardless of earlier status bits, except on the port being serviced.
// - While a notification is uncleared no new one is sent; next follows clearing.
// - Waiting requests are shown per port in the outstanding request vector.
// - Uncleared notification is resent after the programmable retry interval.
// - One destination identifier serves every port of the device.
// - Sixteen-byte payload; offset 0 holds component tag then port error detect word.
// - Offset 8 holds status bits 12-23, port number bits 24-31, logical error word.
// - Packets use the programmable priority, which resets to three.
// - Every packet carries source identifier zero.
// - After clearing, the lowest-numbered port with a waiting request is sent next.
// - Sending sets the originating port's pending flag.
// - Received packet over 276 bytes sets oversize flag and latches capture data.
// - Unexpected packet or control symbol sets protocol flag and latches capture data.
// - Misaligned delimiter or undefined code-group sets delineation flag, no capture.
// - No acknowledge within link timeout sets link timeout flag, no capture.
package pwn_pkg;
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int RETRY_TICK_NS = 1000;
   localparam int RETRY_TICK_CYCLES = (RETRY_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TICK_W = 8;
   // Reset values
   localparam logic [1:0] PRIO_RESET = 2'h3;
   // Packet fields
   localparam logic [7:0] SOURCE_ID = 8'h00;
   localparam logic [1:0] TT_SMALL_ID = 2'h0;
   localparam logic [3:0] FTYPE_MAINT = 4'h8;
   localparam logic [3:0] TTYPE_PORT_WRITE = 4'h4;
   localparam logic [3:0] WRSIZE_16B = 4'hF;
   localparam logic [7:0] TARGET_TID = 8'h00;
   localparam logic [7:0] HOP_COUNT = 8'hFF;
   localparam int PKT_WORDS = 6;
   localparam int WORD_IDX_W = 3;
   // Payload word 2 layout, little-endian positions
   localparam int PORT_NUM_LSB = 0;
   localparam int IMPL_LSB = 8;
   localparam int IMPL_BITS = 12;
   // Error detect word bit positions
   localparam int DET_LINK_TIMEOUT = 0;
   localparam int DET_DELINEATION = 2;
   localparam int DET_PROTOCOL = 4;
   localparam int DET_OVERSIZE = 7;
   localparam int PHYS_EVENTS = 4;
   // Receive size limit
   localparam logic [9:0] MAX_PKT_BYTES = 10'h114;
   localparam int LINK_TIMEOUT_FLAG_W = 24;
endpackage : pwn_pkg

// ### rtl/pwn_port_errors.sv
// Per-port physical layer error detection and capture
`timescale 1ns/10ps
module pwn_port_errors (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Receive observations
   input wire logic rxPktEnd,
   input wire logic [9:0] rxPktBytes,
   input wire logic rxUnexpected,
   input wire logic rxDelinFault,
   input wire logic ackWait,
   input wire logic ackSeen,
   input wire logic [pwn_pkg::LINK_TIMEOUT_FLAG_W-1:0] linkTimeout,
   input wire logic [31:0] captureIn,
   input wire logic detectClear,
   // Results
   output logic [31:0] errDetect,
   output logic [31:0] capture,
   output logic [pwn_pkg::PHYS_EVENTS-1:0] physEvent
);
   typedef struct packed {
      logic [31:0] detect;
      logic [31:0] capture;
      logic [pwn_pkg::LINK_TIMEOUT_FLAG_W-1:0] toCnt;
      logic [pwn_pkg::PHYS_EVENTS-1:0] evt;
   } pwn_perr_s;
   pwn_perr_s s;
   pwn_perr_s next_s;

   always_comb begin
      next_s = s;
      next_s.evt = '0;
      // Clear first so a same-cycle set wins
      if (detectClear) begin
         next_s.detect = '0;
      end
      if (rxPktEnd && rxPktBytes > pwn_pkg::MAX_PKT_BYTES) begin
         next_s.detect[pwn_pkg::DET_OVERSIZE] = 1'b1;
         next_s.capture = captureIn;
         next_s.evt[3] = 1'b1;
      end
      if (rxUnexpected) begin
         next_s.detect[pwn_pkg::DET_PROTOCOL] = 1'b1;
         next_s.capture = captureIn;
         next_s.evt[2] = 1'b1;
      end
      if (rxDelinFault) begin
         next_s.detect[pwn_pkg::DET_DELINEATION] = 1'b1;
         next_s.evt[1] = 1'b1;
      end
      // Zero interval disables the watchdog
      if (!ackWait || ackSeen || linkTimeout == '0) begin
         next_s.toCnt = '0;
      end else if (s.toCnt + 1'b1 >= linkTimeout) begin
         next_s.detect[pwn_pkg::DET_LINK_TIMEOUT] = 1'b1;
         next_s.evt[0] = 1'b1;
         next_s.toCnt = '0;
      end else begin
         next_s.toCnt = s.toCnt + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign errDetect = s.detect;
   assign capture = s.capture;
   assign physEvent = s.evt;
endmodule : pwn_port_errors

// ### rtl/pwn_packet_tx.sv
// Serialiser of one notification packet onto a word stream
`timescale 1ns/10ps
module pwn_packet_tx (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Packet request
   input wire logic start,
   input wire logic [pwn_pkg::PKT_WORDS-1:0][31:0] words,
   output logic busy,
   // Word stream
   output logic txValid,
   output logic [31:0] txData,
   output logic txLast,
   input wire logic txReady
);
   localparam logic [pwn_pkg::WORD_IDX_W-1:0] LAST_IDX = 3'h5;

   typedef struct packed {
      logic busy;
      logic valid;
      logic last;
      logic [pwn_pkg::WORD_IDX_W-1:0] idx;
      logic [31:0] data;
      logic [pwn_pkg::PKT_WORDS-1:0][31:0] buf_w;
   } pwn_tx_s;
   pwn_tx_s s;
   pwn_tx_s next_s;

   always_comb begin
      next_s = s;
      // Words are frozen at start so a moving source cannot tear a packet
      if (start && !s.busy) begin
         next_s.busy = 1'b1;
         next_s.valid = 1'b1;
         next_s.buf_w = words;
         next_s.data = words[0];
         next_s.idx = '0;
         next_s.last = 1'b0;
      end else if (s.valid && txReady) begin
         if (s.idx == LAST_IDX) begin
            next_s.busy = 1'b0;
            next_s.valid = 1'b0;
            next_s.last = 1'b0;
         end else begin
            next_s.idx = s.idx + 1'b1;
            next_s.data = s.buf_w[s.idx + 1'b1];
            next_s.last = (s.idx + 1'b1 == LAST_IDX);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign busy = s.busy;
   assign txValid = s.valid;
   assign txData = s.data;
   assign txLast = s.last;
endmodule : pwn_packet_tx

// ### rtl/pwn_notifier.sv
// Top of the port-write notification generator
`timescale 1ns/10ps
module pwn_notifier #(
   parameter int NPORTS = 16,
   parameter int RETRY_W = 24
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Device-wide configuration
   input wire logic [7:0] targetDestId,
   input wire logic [31:0] componentTag,
   input wire logic [31:0] logicalErrDetect,
   input wire logic [RETRY_W-1:0] notifyRetryInterval,
   input wire logic priorityWrite,
   input wire logic [1:0] priorityData,
   // Per-port configuration
   input wire logic [NPORTS-1:0] notifyDisable,
   input wire logic [NPORTS-1:0][pwn_pkg::IMPL_BITS-1:0] implEvent,
   input wire logic [NPORTS-1:0][pwn_pkg::IMPL_BITS-1:0] implEnable,
   input wire logic [NPORTS-1:0][pwn_pkg::IMPL_BITS-1:0] implStatus,
   input wire logic [NPORTS-1:0][pwn_pkg::PHYS_EVENTS-1:0] physEnable,
   input wire logic [NPORTS-1:0][pwn_pkg::LINK_TIMEOUT_FLAG_W-1:0] linkTimeout,
   // Per-port receive observations
   input wire logic [NPORTS-1:0] rxPktEnd,
   input wire logic [NPORTS-1:0][9:0] rxPktBytes,
   input wire logic [NPORTS-1:0] rxUnexpected,
   input wire logic [NPORTS-1:0] rxDelinFault,
   input wire logic [NPORTS-1:0] ackWait,
   input wire logic [NPORTS-1:0] ackSeen,
   input wire logic [NPORTS-1:0][31:0] captureIn,
   // Host clearing
   input wire logic [NPORTS-1:0] detectClear,
   input wire logic [NPORTS-1:0] pendingClear,
   // Status
   output logic [NPORTS-1:0] notifyPendingFlag,
   output logic [NPORTS-1:0] outstandingRequest,
   output logic [NPORTS-1:0][31:0] errDetect,
   output logic [NPORTS-1:0][31:0] capture,
   output logic [1:0] notifyPriority,
   // Packet stream
   output logic txValid,
   output logic [31:0] txData,
   output logic txLast,
   input wire logic txReady
);
   typedef struct packed {
      logic [NPORTS-1:0] pending;
      logic [NPORTS-1:0] outstanding;
      logic active;
      logic [7:0] curPort;
      logic [RETRY_W-1:0] retryCnt;
      logic [pwn_pkg::TICK_W-1:0] div;
      logic tick;
      logic [1:0] prio;
      logic startTx;
   } pwn_top_s;
   pwn_top_s s;
   pwn_top_s next_s;

   logic [NPORTS-1:0][pwn_pkg::PHYS_EVENTS-1:0] physEvent;
   logic [NPORTS-1:0] qualEvent;
   logic [pwn_pkg::PKT_WORDS-1:0][31:0] pktWords;
   logic [31:0] statusWord;
   logic txBusy;

   localparam logic [pwn_pkg::TICK_W-1:0] TICK_LAST =
      pwn_pkg::TICK_W'(pwn_pkg::RETRY_TICK_CYCLES - 1);

   // Per-port error detection and event qualification
   genvar gp;
   generate
      for (gp = 0; gp < NPORTS; gp++) begin : g_port
         pwn_port_errors u_err (
            .clk(clk),
            .rst(rst),
            .rxPktEnd(rxPktEnd[gp]),
            .rxPktBytes(rxPktBytes[gp]),
            .rxUnexpected(rxUnexpected[gp]),
            .rxDelinFault(rxDelinFault[gp]),
            .ackWait(ackWait[gp]),
            .ackSeen(ackSeen[gp]),
            .linkTimeout(linkTimeout[gp]),
            .captureIn(captureIn[gp]),
            .detectClear(detectClear[gp]),
            .errDetect(errDetect[gp]),
            .capture(capture[gp]),
            .physEvent(physEvent[gp])
         );
         // Status bits still record; only enabled events qualify
         assign qualEvent[gp] = (|(implEvent[gp] & implEnable[gp])
            || |(physEvent[gp] & physEnable[gp])) && !notifyDisable[gp];
      end
   endgenerate

   // Payload word 2: status bits 12..23 land at 19..8, port number in the low byte
   always_comb begin
      statusWord = '0;
      for (int b = 0; b < pwn_pkg::IMPL_BITS; b++) begin
         statusWord[pwn_pkg::IMPL_LSB + b] =
            implStatus[s.curPort[$clog2(NPORTS)-1:0]][b];
      end
      statusWord[pwn_pkg::PORT_NUM_LSB +: 8] = s.curPort;
   end

   // Maintenance port-write, no response expected
   always_comb begin
      pktWords[0] = {s.prio, pwn_pkg::TT_SMALL_ID, pwn_pkg::FTYPE_MAINT,
         targetDestId, pwn_pkg::SOURCE_ID,
         pwn_pkg::TTYPE_PORT_WRITE, pwn_pkg::WRSIZE_16B};
      pktWords[1] = {pwn_pkg::TARGET_TID, pwn_pkg::HOP_COUNT, 16'h0000};
      pktWords[2] = componentTag;
      pktWords[3] = errDetect[s.curPort[$clog2(NPORTS)-1:0]];
      pktWords[4] = statusWord;
      pktWords[5] = logicalErrDetect;
   end

   always_comb begin
      next_s = s;
      next_s.startTx = 1'b0;
      next_s.tick = 1'b0;
      // Retry time base, one enable pulse per tick
      if (s.div == TICK_LAST) begin
         next_s.div = '0;
         next_s.tick = 1'b1;
      end else begin
         next_s.div = s.div + 1'b1;
      end
      if (priorityWrite) begin
         next_s.prio = priorityData;
      end
      // Requests queue per port; the port being serviced takes no new packet
      for (int p = 0; p < NPORTS; p++) begin
         if (qualEvent[p] && !(s.active && s.curPort == 8'(p))) begin
            next_s.outstanding[p] = 1'b1;
         end
         // Pending holds while error detect is nonzero
         if (pendingClear[p] && errDetect[p] == '0) begin
            next_s.pending[p] = 1'b0;
         end
      end
      // Disabling a waiting port drops its request
      next_s.outstanding = next_s.outstanding & ~notifyDisable;
      if (s.active) begin
         if (!s.pending[s.curPort[$clog2(NPORTS)-1:0]]) begin
            next_s.active = 1'b0;
            next_s.retryCnt = '0;
         end else if (s.tick && notifyRetryInterval != '0) begin
            // Resend only once the previous copy has left
            if (s.retryCnt + 1'b1 >= notifyRetryInterval && !txBusy) begin
               next_s.retryCnt = '0;
               next_s.startTx = 1'b1;
            end else if (s.retryCnt + 1'b1 < notifyRetryInterval) begin
               next_s.retryCnt = s.retryCnt + 1'b1;
            end
         end
      end else if (!txBusy && !s.startTx) begin
         // Lowest-numbered waiting port wins
         for (int p = NPORTS - 1; p >= 0; p--) begin
            if (s.outstanding[p] && !notifyDisable[p]) begin
               next_s.curPort = 8'(p);
            end
         end
         if (|(s.outstanding & ~notifyDisable)) begin
            next_s.active = 1'b1;
            next_s.startTx = 1'b1;
            next_s.retryCnt = '0;
            next_s.pending[next_s.curPort[$clog2(NPORTS)-1:0]] = 1'b1;
            next_s.outstanding[next_s.curPort[$clog2(NPORTS)-1:0]] = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
         s.prio <= pwn_pkg::PRIO_RESET;
      end else begin
         s <= next_s;
      end
   end

   pwn_packet_tx u_tx (
      .clk(clk),
      .rst(rst),
      .start(s.startTx),
      .words(pktWords),
      .busy(txBusy),
      .txValid(txValid),
      .txData(txData),
      .txLast(txLast),
      .txReady(txReady)
   );

   assign notifyPendingFlag = s.pending;
   assign outstandingRequest = s.outstanding;
   assign notifyPriority = s.prio;
endmodule : pwn_notifier

// ### dv/pwn_notifier_chk.sv
// Assertion checker for the notification generator
`timescale 1ns/10ps
module pwn_notifier_chk #(
   parameter int NPORTS = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Watched inputs
   input wire logic [7:0] targetDestId,
   input wire logic priorityWrite,
   input wire logic [1:0] priorityData,
   input wire logic [NPORTS-1:0] notifyDisable,
   input wire logic txReady,
   // Watched outputs
   input wire logic [NPORTS-1:0] notifyPendingFlag,
   input wire logic [NPORTS-1:0] outstandingRequest,
   input wire logic [NPORTS-1:0][31:0] errDetect,
   input wire logic [1:0] notifyPriority,
   input wire logic txValid,
   input wire logic [31:0] txData,
   input wire logic txLast
);
   logic [2:0] wordIdx;
   logic [NPORTS-1:0] keepMask;
   // Word position, and pending ports whose detect word still blocks clearing
   always_ff @(posedge clk) begin
      if (rst) begin
         wordIdx <= 3'h0;
         keepMask <= '0;
      end else begin
         if (txValid && txReady) wordIdx <= txLast ? 3'h0 : wordIdx + 3'h1;
         for (int i = 0; i < NPORTS; i++) keepMask[i] <= notifyPendingFlag[i] && |errDetect[i];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_stall;
      txValid && !txReady;
   endsequence
   sequence s_head;
      txValid && wordIdx == 3'h0;
   endsequence
   a_prio_after_reset: assert property ($fell(rst) |-> notifyPriority == 2'h3)
      else $error("priority not three after reset");
   a_prio_load: assert property (priorityWrite |=> notifyPriority == $past(priorityData))
      else $error("priority not loaded");
   a_head_fields: assert property (s_head |-> txData == {notifyPriority, 6'h08, targetDestId, 16'h004F})
      else $error("bad header word");
   a_last_word: assert property (txValid |-> txLast == (wordIdx == 3'h5))
      else $error("last marker misplaced");
   a_word_hold: assert property (s_stall |=> txValid && $stable(txData) && $stable(txLast))
      else $error("word changed while stalled");
   a_one_pending: assert property ($onehot0(notifyPendingFlag))
      else $error("several notifications pending");
   a_pend_on_send: assert property (s_head |-> notifyPendingFlag != '0)
      else $error("packet sent without pending flag");
   a_pend_held: assert property ((keepMask & ~notifyPendingFlag) == '0)
      else $error("pending cleared with detect word set");
   a_dis_drop: assert property ((notifyDisable & outstandingRequest) != '0 |=>
      (outstandingRequest & $past(notifyDisable)) == '0)
      else $error("disabled port kept its request");
endmodule : pwn_notifier_chk
bind pwn_notifier pwn_notifier_chk #(.NPORTS(NPORTS)) u_pwn_notifier_chk (.*);

// ### dv/pwn_host_model.sv
// Host model that receives notification packets
`timescale 1ns/10ps
module pwn_host_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Stall control
   input wire logic slow,
   // Packet stream
   input wire logic txValid,
   input wire logic [31:0] txData,
   input wire logic txLast,
   output logic txReady,
   // Received packet
   output logic pktDone,
   output logic [5:0][31:0] pkt
);
   int idx;
   always @(posedge clk) begin
      pktDone <= 1'b0;
      if (rst) begin
         idx = 0;
         txReady <= 1'b0;
      end else begin
         if (txValid && txReady) begin
            pkt[idx] <= txData;
            idx = txLast ? 0 : idx + 1;
            pktDone <= txLast; // Nothing is answered
         end
         // Slow mode is ready every other cycle only
         txReady <= slow ? ~txReady : 1'b1;
      end
   end
endmodule : pwn_host_model

// ### dv/pwn_notifier_tb.sv
// Self-checking bench for the notification generator
`timescale 1ns/10ps
module pwn_notifier_tb;
   typedef logic [5:0][31:0] pwn_pkt_t;
   localparam int NP = 4;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] targetDestId;
   logic [31:0] componentTag, logicalErrDetect, txData, cap;
   logic [23:0] notifyRetryInterval;
   logic [1:0] priorityData, notifyPriority, prio;
   logic priorityWrite, txValid, txLast, txReady, pktDone, slow;
   logic [NP-1:0] notifyDisable, rxPktEnd, rxUnexpected, rxDelinFault, ackWait, ackSeen;
   logic [NP-1:0] detectClear, pendingClear, notifyPendingFlag, outstandingRequest;
   logic [NP-1:0][11:0] implEvent, implEnable, implStatus;
   logic [NP-1:0][3:0] physEnable;
   logic [NP-1:0][23:0] linkTimeout;
   logic [NP-1:0][9:0] rxPktBytes;
   logic [NP-1:0][31:0] captureIn, errDetect, capture;
   logic [3:0][31:0] detTab = {32'h01, 32'h04, 32'h10, 32'h80};
   pwn_pkt_t pkt;
   pwn_pkt_t expQ[$];
   int seed = 60149;
   int mismatches = 0;
   int checks_done = 0;
   int cyc = 0;
   pwn_notifier #(.NPORTS(NP)) u_pwn_notifier (.*);
   pwn_host_model u_pwn_host_model (.*);
   always #5 clk = ~clk;
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : complete_run
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
      end
   endtask : chk_val
   task automatic chk_pkt(input pwn_pkt_t got, input pwn_pkt_t exp);
      for (int i = 0; i < 6; i++) chk_val(got[i], exp[i], "packet word");
   endtask : chk_pkt
   function automatic pwn_pkt_t expect_pkt(input int p, input logic [31:0] det);
      return {logicalErrDetect, 12'h000, implStatus[p], 8'(p), det, componentTag,
         32'h00FF0000, prio, 6'h08, targetDestId, 16'h004F};
   endfunction : expect_pkt
   // Result watcher; a stray packet counts as a mismatch
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         complete_run();
      end
      if (pktDone) begin
         if (expQ.size() == 0) chk_val(32'h1, 32'h0, "stray packet");
         else chk_pkt(pkt, expQ.pop_front());
      end
   end
   task automatic tick(input int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic drain(input int lim);
      int n;
      n = 0;
      while (expQ.size() != 0 && n < lim) begin
         tick();
         n++;
      end
      chk_val(expQ.size(), 0, "packet missing");
   endtask : drain
   task automatic serve(input int p);
      detectClear[p] = 1'b1;
      tick();
      detectClear[p] = 1'b0;
      pendingClear[p] = 1'b1;
      tick();
      pendingClear[p] = 1'b0;
      tick(3);
   endtask : serve
   task automatic fire_impl(input int p, input int b);
      implEvent[p][b] = 1'b1;
      tick();
      implEvent[p][b] = 1'b0;
   endtask : fire_impl
   initial begin
      targetDestId = 8'($random(seed));
      componentTag = $random(seed);
      logicalErrDetect = $random(seed);
      implStatus = 48'({$random(seed), $random(seed)});
      captureIn = {4{32'($random(seed))}};
      implEnable = '1;
      implEnable[1][0] = 1'b0;
      physEnable = '1;
      {notifyDisable, rxPktEnd, rxUnexpected, rxDelinFault, ackWait, ackSeen} = '0;
      {detectClear, pendingClear, implEvent, linkTimeout, rxPktBytes} = '0;
      {priorityWrite, priorityData, notifyRetryInterval, slow} = '0;
      prio = 2'h3;
      tick(4);
      rst = 1'b0;
      chk_val(notifyPriority, prio, "reset priority");
      prio = 2'($random(seed));
      priorityData = prio;
      priorityWrite = 1'b1;
      tick();
      priorityWrite = 1'b0;
      tick();
      chk_val(notifyPriority, prio, "priority");
      $display("test reset and priority done");
      fire_impl(1, 0);
      notifyDisable[0] = 1'b1;
      fire_impl(0, 2);
      tick(30);
      chk_val(outstandingRequest, 0, "masked events");
      notifyDisable[0] = 1'b0;
      $display("test masking done");
      fire_impl(2, 5);
      expQ.push_back(expect_pkt(2, 0));
      drain(60);
      chk_val(notifyPendingFlag, 4'h4, "pending flag");
      implEvent[0][1] = 1'b1;
      implEvent[1][3] = 1'b1;
      implEvent[2][7] = 1'b1;
      implEvent[3][4] = 1'b1;
      tick();
      implEvent = '0;
      tick(20);
      chk_val(outstandingRequest, 4'hB, "outstanding");
      notifyDisable[0] = 1'b1;
      tick(2);
      chk_val(outstandingRequest, 4'hA, "disable drop");
      notifyDisable[0] = 1'b0;
      slow = 1'b1;
      serve(2);
      expQ.push_back(expect_pkt(1, 0));
      drain(60);
      serve(1);
      expQ.push_back(expect_pkt(3, 0));
      drain(60);
      serve(3);
      fire_impl(2, 5);
      expQ.push_back(expect_pkt(2, 0));
      drain(60);
      serve(2);
      $display("test arbitration done");
      rxPktBytes[0] = 10'h114;
      rxPktEnd[0] = 1'b1;
      tick();
      rxPktEnd[0] = 1'b0;
      tick(3);
      chk_val(errDetect[0], 0, "size limit");
      // Acks every fourth cycle keep a five-cycle watchdog quiet
      linkTimeout[2] = 24'h5;
      ackWait[2] = 1'b1;
      repeat (4) begin
         tick(3);
         ackSeen[2] = 1'b1;
         tick();
         ackSeen[2] = 1'b0;
      end
      ackWait[2] = 1'b0;
      tick();
      chk_val(errDetect[2], 0, "ack in time");
      rxPktBytes[0] = 10'h115;
      linkTimeout[3] = 24'h5;
      for (int k = 0; k < 4; k++) begin
         captureIn[k] = $random(seed);
         cap = captureIn[k];
         rxPktEnd[k] = (k == 0);
         rxUnexpected[k] = (k == 1);
         rxDelinFault[k] = (k == 2);
         ackWait[k] = (k == 3);
         tick();
         {rxPktEnd, rxUnexpected, rxDelinFault} = '0;
         for (int n = 0; n < 20 && errDetect[k] !== detTab[k]; n++) tick();
         ackWait = '0;
         expQ.push_back(expect_pkt(k, detTab[k]));
         drain(60);
         chk_val(capture[k], k < 2 ? cap : 32'h0, "capture");
         pendingClear[k] = 1'b1;
         tick();
         pendingClear[k] = 1'b0;
         tick();
         chk_val(notifyPendingFlag[k], 1'b1, "clear refused");
         serve(k);
         chk_val(notifyPendingFlag[k], 1'b0, "clear taken");
      end
      $display("test line errors done");
      notifyRetryInterval = 24'h1;
      fire_impl(3, 4);
      expQ.push_back(expect_pkt(3, 0));
      expQ.push_back(expect_pkt(3, 0));
      drain(300);
      serve(3);
      notifyRetryInterval = '0;
      tick(150);
      $display("test retry done");
      complete_run();
   end
endmodule : pwn_notifier_tb
